// ==== hw/fsp_pkg.sv ====
// constants and carrier types of the flash self-program controller
package fsp_pkg;
  // array geometry
  localparam int ROW_INSTR = 32;
  localparam int PANEL_ROWS = 128;
  localparam int INSTR_W = 24;
  localparam int LIDX_W = $clog2(ROW_INSTR);
  localparam int ROW_LSB = LIDX_W + 1;
  localparam int PANEL_LSB = ROW_LSB + $clog2(PANEL_ROWS);
  localparam int PANEL_W = INSTR_W - PANEL_LSB;
  localparam int ROWSEL_W = PANEL_LSB - ROW_LSB;
  localparam int LATCH_W = ROW_INSTR * INSTR_W;

  // register indices; the byte address is four times the index
  localparam int PADDR_W = 16;
  localparam logic [11:0] IDX_CTRL = 12'h760;
  localparam logic [11:0] IDX_ADRL = 12'h762;
  localparam logic [11:0] IDX_ADRU = 12'h764;
  localparam logic [11:0] IDX_KEY = 12'h766;

  // control register fields
  localparam int CB_START = 15;
  localparam int CB_WRITE_ENABLE_BIT = 14;
  localparam int CB_ERR = 13;
  localparam int OP_W = 7;
  localparam logic [OP_W-1:0] OP_ROW_ERASE = 7'h41;
  localparam logic [OP_W-1:0] OP_ROW_PROG = 7'h01;
  localparam logic [OP_W-1:0] OP_RST = 7'h00;
  localparam logic [15:0] ADRL_RST = 16'h0000;
  localparam logic [7:0] ADRU_RST = 8'h00;

  // unlock key values
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // timing: nominal operation length, rounded down to whole cycles
  localparam int OP_TIME_NS = 2000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;

  // one table instruction from the core
  typedef struct packed {
    logic isWrite;
    logic isHigh;
    logic byteMode;
    logic byteSel;
    logic [15:0] ea;
    logic [15:0] wdata;
  } fsp_tbl_req_t;

  // command held towards the flash array during an operation
  typedef struct packed {
    logic erase;
    logic prog;
    logic [PANEL_W-1:0] panel;
    logic [ROWSEL_W-1:0] row;
  } fsp_flash_cmd_t;

  typedef enum logic [1:0] {K_IDLE, K_GOT_FIRST, K_ARMED} fsp_key_t;
  typedef enum logic {OP_IDLE, OP_RUN} fsp_op_t;
endpackage

// ==== hw/fsp_op_timer.sv ====
// counts out the length of one erase or program operation
`timescale 1ns/1ps
module fsp_op_timer #(
  parameter int CYCLES = fsp_pkg::OP_CYCLES
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic start,
  output logic done
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);
  localparam logic [CNT_W-1:0] ZERO = '0;

  if (CYCLES < 2) begin : g_bad_cycles
    $error("operation length must be at least 2 cycles");
  end

  logic [CNT_W-1:0] count_q;
  logic running_q;

  // free counter while running, done in the same cycle as the last count
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= ZERO;
      running_q <= 1'b0;
    end else if (start) begin
      count_q <= ZERO;
      running_q <= 1'b1;
    end else if (running_q) begin
      count_q <= count_q + CNT_W'(1);
      if (count_q == LAST) running_q <= 1'b0;
    end
  end

  assign done = running_q && (count_q == LAST);
endmodule

// ==== hw/fsp_ctrl.sv ====
// flash self-program controller: latches, unlock, operation sequencing
//
// Functional notes
// - flash is rows of 32 instructions, 128 rows make one panel.
// - an erase clears exactly one 32-instruction row.
// - a program writes 32 instructions at once from the latches.
// - the panel latches hold 32 instructions, filled before programming.
// - low table access covers bits 15..0, word or byte.
// - high table access covers bits 23..16, word or byte.
// - program address is table page joined with the effective address.
// - a table write finishes in two cycles, latches only.
// - low address register captures ea 15..0 of each table access.
// - upper address register captures bits 23..16 of each access.
// - software may write both address registers directly.
// - key register is write-only; 0x55 then 0xaa back to back.
// - start bit 15 launches; hardware clears it when finished.
// - an operation lasts nominally 2 ms and stalls the core.
// - control register picks erase or program and holds start.
`timescale 1ns/1ps
module fsp_ctrl
  import fsp_pkg::*;
#(
  parameter int OP_LEN = fsp_pkg::OP_CYCLES
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fsp_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tblValid,
  input wire fsp_pkg::fsp_tbl_req_t tblReq,
  input wire logic [7:0] tablePage,
  output logic tblReady,
  output logic tblDone,
  output logic [15:0] tblRdData,
  output logic [fsp_pkg::INSTR_W-1:0] pmAddr,
  input wire logic [fsp_pkg::INSTR_W-1:0] pmRdData,
  output fsp_pkg::fsp_flash_cmd_t flashCmd,
  output logic [fsp_pkg::LATCH_W-1:0] flashLatchData,
  output logic cpuStall
);
  import fsp_pkg::*;

  if (OP_LEN < 2) begin : g_bad_len
    $error("OP_LEN must be at least 2");
  end

  // register index from a byte address
  function automatic logic [11:0] reg_index(logic [PADDR_W-1:0] a);
    return a[13:2];
  endfunction

  // true when a byte address hits a mapped register
  function automatic logic is_mapped(logic [PADDR_W-1:0] a);
    logic [11:0] i;
    i = reg_index(a);
    return (a[1:0] == 2'b00) && (a[PADDR_W-1:14] == '0) &&
      (i == IDX_CTRL || i == IDX_ADRL || i == IDX_ADRU || i == IDX_KEY);
  endfunction

  // merge one table write into an instruction latch
  function automatic logic [INSTR_W-1:0] latch_merge(
      logic [INSTR_W-1:0] old, fsp_tbl_req_t r);
    logic [INSTR_W-1:0] v;
    v = old;
    if (r.isHigh) begin
      // the phantom byte above bit 23 does not exist
      if (!(r.byteMode && r.byteSel)) v[23:16] = r.wdata[7:0];
    end else if (!r.byteMode) begin
      v[15:0] = r.wdata;
    end else if (r.byteSel) begin
      v[15:8] = r.wdata[7:0];
    end else begin
      v[7:0] = r.wdata[7:0];
    end
    return v;
  endfunction

  // pick the half or byte of a program word that a table read asks for
  function automatic logic [15:0] read_pick(
      logic [INSTR_W-1:0] w, fsp_tbl_req_t r);
    logic [15:0] v;
    v = 16'h0000;
    if (r.isHigh) begin
      if (!(r.byteMode && r.byteSel)) v[7:0] = w[23:16];
    end else if (!r.byteMode) begin
      v = w[15:0];
    end else if (r.byteSel) begin
      v[7:0] = w[15:8];
    end else begin
      v[7:0] = w[7:0];
    end
    return v;
  endfunction

  // bus decode
  logic apbSetup;
  logic apbWr;
  logic [11:0] wrIdx;
  assign apbSetup = psel && !penable;
  assign apbWr = psel && penable && pwrite && is_mapped(paddr);
  assign wrIdx = reg_index(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);

  // state
  fsp_op_t opState_q;
  fsp_key_t keyStage_q;
  logic write_enable_bit_q;
  logic err_q;
  logic [OP_W-1:0] opSel_q;
  logic [15:0] addrLow_q;
  logic [7:0] addrUp_q;
  logic [INSTR_W-1:0] latch_q [ROW_INSTR];
  logic rdWait_q;
  fsp_tbl_req_t rdReq_q;
  logic [15:0] tblRdData_q;
  logic tblDone_q;
  logic [INSTR_W-1:0] pmAddr_q;
  logic [31:0] prdata_q;
  fsp_flash_cmd_t flashCmd_q;
  logic opDone;

  // start attempt and its gating
  logic startReq;
  logic opLegal;
  logic launch;
  logic tblTake;
  logic [INSTR_W-1:0] opAddr;
  assign startReq = apbWr && wrIdx == IDX_CTRL && pwdata[CB_START] &&
    opState_q == OP_IDLE;
  assign opLegal = pwdata[OP_W-1:0] == OP_ROW_ERASE ||
    pwdata[OP_W-1:0] == OP_ROW_PROG;
  assign launch = startReq && keyStage_q == K_ARMED &&
    pwdata[CB_WRITE_ENABLE_BIT] && opLegal;
  assign tblTake = tblValid && tblReady;
  assign opAddr = {addrUp_q, addrLow_q};

  // two-step unlock; any other write to a mapped register breaks it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      keyStage_q <= K_IDLE;
    end else if (apbWr) begin
      if (wrIdx == IDX_KEY && pwdata[7:0] == KEY_FIRST) begin
        keyStage_q <= K_GOT_FIRST;
      end else if (wrIdx == IDX_KEY && pwdata[7:0] == KEY_SECOND &&
          keyStage_q == K_GOT_FIRST) begin
        keyStage_q <= K_ARMED;
      end else begin
        keyStage_q <= K_IDLE;
      end
    end
  end

  // control fields; frozen while an operation runs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      write_enable_bit_q <= 1'b0;
      opSel_q <= OP_RST;
    end else if (apbWr && wrIdx == IDX_CTRL && opState_q == OP_IDLE) begin
      write_enable_bit_q <= pwdata[CB_WRITE_ENABLE_BIT];
      opSel_q <= pwdata[OP_W-1:0];
    end
  end

  // refused start sets the error flag; a new refusal beats the clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      err_q <= 1'b0;
    end else if (startReq && !launch) begin
      err_q <= 1'b1;
    end else if (apbWr && wrIdx == IDX_CTRL && !pwdata[CB_ERR]) begin
      err_q <= 1'b0;
    end
  end

  // start bit reads as the run state, cleared by hardware at the end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      opState_q <= OP_IDLE;
    end else begin
      case (opState_q)
        OP_IDLE: begin
          if (launch) opState_q <= OP_RUN;
        end
        OP_RUN: begin
          if (opDone) opState_q <= OP_IDLE;
        end
        default: opState_q <= OP_IDLE;
      endcase
    end
  end

  fsp_op_timer #(
    .CYCLES(OP_LEN)
  ) u_timer (
    .mclk(mclk),
    .arst_n(arst_n),
    .start(launch),
    .done(opDone)
  );
  assign cpuStall = opState_q == OP_RUN;

  // one-row erase, one-row program, panel and row split
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flashCmd_q <= '0;
    end else if (launch) begin
      flashCmd_q.erase <= pwdata[OP_W-1:0] == OP_ROW_ERASE;
      flashCmd_q.prog <= pwdata[OP_W-1:0] == OP_ROW_PROG;
      flashCmd_q.panel <= opAddr[INSTR_W-1:PANEL_LSB];
      flashCmd_q.row <= opAddr[PANEL_LSB-1:ROW_LSB];
    end else if (opDone) begin
      flashCmd_q <= '0;
    end
  end
  assign flashCmd = flashCmd_q;

  // capture on table access, direct writes take over
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      addrLow_q <= ADRL_RST;
      addrUp_q <= ADRU_RST;
    end else if (apbWr && opState_q == OP_IDLE &&
        (wrIdx == IDX_ADRL || wrIdx == IDX_ADRU)) begin
      if (wrIdx == IDX_ADRL) addrLow_q <= pwdata[15:0];
      else addrUp_q <= pwdata[7:0];
    end else if (tblTake) begin
      addrLow_q <= tblReq.ea;
      addrUp_q <= tablePage;
    end
  end

  // table port waits during an operation and behind a pending read
  assign tblReady = opState_q == OP_IDLE && !rdWait_q;

  // one latch set; halves and bytes; index from ea
  generate
    for (genvar i = 0; i < ROW_INSTR; i++) begin : g_latch
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          latch_q[i] <= '0;
        end else if (tblTake && tblReq.isWrite &&
            tblReq.ea[LIDX_W:1] == LIDX_W'(i)) begin
          latch_q[i] <= latch_merge(latch_q[i], tblReq);
        end
      end
      assign flashLatchData[i*INSTR_W +: INSTR_W] = latch_q[i];
    end
  endgenerate

  // write done next cycle; read needs one more for the array
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdWait_q <= 1'b0;
      tblDone_q <= 1'b0;
      rdReq_q <= '0;
    end else begin
      rdWait_q <= tblTake && !tblReq.isWrite;
      tblDone_q <= (tblTake && tblReq.isWrite) || rdWait_q;
      if (tblTake) rdReq_q <= tblReq;
    end
  end
  assign tblDone = tblDone_q;

  // program address is page joined with ea
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pmAddr_q <= '0;
    end else if (tblTake) begin
      pmAddr_q <= {tablePage, tblReq.ea};
    end
  end
  assign pmAddr = pmAddr_q;

  // read data held until the next read completes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tblRdData_q <= 16'h0000;
    end else if (rdWait_q) begin
      tblRdData_q <= read_pick(pmRdData, rdReq_q);
    end
  end
  assign tblRdData = tblRdData_q;

  // read data is fetched in the setup cycle so the access has no wait
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (apbSetup) begin
      prdata_q <= 32'h0000_0000;
      if (is_mapped(paddr)) begin
        case (reg_index(paddr))
          IDX_CTRL: begin
            prdata_q[CB_START] <= opState_q == OP_RUN;
            prdata_q[CB_WRITE_ENABLE_BIT] <= write_enable_bit_q;
            prdata_q[CB_ERR] <= err_q;
            prdata_q[OP_W-1:0] <= opSel_q;
          end
          IDX_ADRL: prdata_q[15:0] <= addrLow_q;
          IDX_ADRU: prdata_q[7:0] <= addrUp_q;
          default: prdata_q <= 32'h0000_0000; // key is write-only
        endcase
      end
    end
  end
  assign prdata = prdata_q;

  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_key_gate: assert property (
    launch |-> keyStage_q == K_ARMED)
    else $error("start launched without key pair");
  a_key_arm: assert property (
    keyStage_q == K_ARMED && $past(keyStage_q) != K_ARMED |->
      $past(apbWr) && $past(wrIdx) == IDX_KEY &&
      $past(pwdata[7:0]) == KEY_SECOND && $past(keyStage_q) == K_GOT_FIRST)
    else $error("key armed without first and second key writes");
  a_key_break: assert property (
    apbWr && wrIdx != IDX_KEY |=> keyStage_q == K_IDLE)
    else $error("key sequence survived a foreign write");
  a_write_enable_bit_gate: assert property (
    startReq && !pwdata[CB_WRITE_ENABLE_BIT] |=> opState_q == OP_IDLE)
    else $error("operation began with write enable clear");
  a_stall_run: assert property (
    launch |=> cpuStall [*8])
    else $error("core not stalled after launch");
  a_start_clear: assert property (
    opDone |=> opState_q == OP_IDLE && !cpuStall &&
      !flashCmd.erase && !flashCmd.prog)
    else $error("start bit not cleared at operation end");
  a_row_cmd: assert property (
    launch && pwdata[OP_W-1:0] == OP_ROW_ERASE |=>
      flashCmd.erase && !flashCmd.prog &&
      flashCmd.row == $past(opAddr[PANEL_LSB-1:ROW_LSB]))
    else $error("erase command does not name one row");
  a_tbl_two: assert property (
    tblTake && tblReq.isWrite |=> tblDone ##1 (!tblDone || $past(tblTake)))
    else $error("table write not done in two cycles");
  a_addr_cap: assert property (
    tblTake && !apbWr |=> addrLow_q == $past(tblReq.ea) &&
      addrUp_q == $past(tablePage))
    else $error("address registers missed table access");
  a_latch_low: assert property (
    tblTake && tblReq.isWrite && !tblReq.isHigh && !tblReq.byteMode
      |=> flashLatchData[$past(tblReq.ea[LIDX_W:1])*INSTR_W +: 16]
        == $past(tblReq.wdata))
    else $error("low word not stored in latch");
  a_pm_addr: assert property (
    tblTake |=> pmAddr == {$past(tablePage), $past(tblReq.ea)})
    else $error("program address not page joined with ea");
endmodule

// ==== tb/fsp_core_model.sv ====
// processor core model: issues table instructions, stands in for the array
`timescale 1ns/1ps
module fsp_core_model (
  input wire logic mclk,
  input wire logic tblReady,
  input wire logic tblDone,
  input wire logic [15:0] tblRdData,
  input wire logic [fsp_pkg::INSTR_W-1:0] pmAddr,
  output fsp_pkg::fsp_tbl_req_t tblReq,
  output logic tblValid,
  output logic [fsp_pkg::INSTR_W-1:0] pmRdData
);
  import fsp_pkg::*;

  // array content is a fixed scramble of the address, so reads are checkable
  assign pmRdData = {pmAddr[7:0] ^ 8'ha5, pmAddr[15:0] ^ 16'h3c3c};

  // idle request after time zero
  initial begin
    tblValid = 1'b0;
    tblReq = '0;
  end

  // one table instruction; held until taken, then the bus is scrambled
  task automatic tbl(input logic wr, input logic hi, input logic [15:0] ea,
                     input logic [15:0] wd, output logic [15:0] rd,
                     output int n);
    int k;
    k = 0;
    tblReq <= '{wr, hi, 1'b0, 1'b0, ea, wd};
    tblValid <= 1'b1;
    @(negedge mclk);
    while (tblReady !== 1'b1 && k < 50) begin
      @(negedge mclk);
      k++;
    end
    @(posedge mclk);
    tblValid <= 1'b0;
    tblReq <= fsp_tbl_req_t'(~tblReq);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (tblDone !== 1'b1 && n < 50);
    rd = tblRdData;
    @(posedge mclk);
  endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench of the flash self-program controller
`timescale 1ns/1ps
module testbench;
  import fsp_pkg::*;
  localparam int OPL = 20;
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, serr;
  logic [15:0] paddr, tblRdData, rdt, base, wd;
  logic [31:0] pwdata, prdata, rd;
  logic tblValid, tblReady, tblDone, cpuStall;
  logic [7:0] tablePage;
  logic [23:0] pmAddr, pmRdData, adr, x;
  logic [LATCH_W-1:0] flashLatchData;
  fsp_tbl_req_t tblReq;
  fsp_flash_cmd_t flashCmd;
  logic [23:0] lat [ROW_INSTR];
  int n_fail, tests_run, seed, n;

  fsp_ctrl #(.OP_LEN(OPL)) DUT (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tblValid(tblValid), .tblReq(tblReq), .tablePage(tablePage),
    .tblReady(tblReady), .tblDone(tblDone), .tblRdData(tblRdData),
    .pmAddr(pmAddr), .pmRdData(pmRdData), .flashCmd(flashCmd),
    .flashLatchData(flashLatchData), .cpuStall(cpuStall));

  fsp_core_model core (.mclk(mclk), .tblReady(tblReady), .tblDone(tblDone),
    .tblRdData(tblRdData), .pmAddr(pmAddr), .tblReq(tblReq),
    .tblValid(tblValid), .pmRdData(pmRdData));

  // 100 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // expected array content, worked out apart from the model
  function automatic logic [23:0] arr(input logic [23:0] a);
    return {a[7:0] ^ 8'ha5, a[15:0] ^ 16'h3c3c};
  endfunction

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // one apb transfer; pready decides when the access phase ends
  task automatic apb(input logic wr, input logic [11:0] idx,
                     input logic [31:0] wdat, output logic [31:0] r,
                     output logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wdat;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge mclk);
      k++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // key pair then start; brk slips a foreign write between the keys
  task automatic do_op(input logic [15:0] c, input logic brk,
                       input logic ers, input logic pg, input logic on);
    fsp_flash_cmd_t e;
    e = on ? fsp_flash_cmd_t'({ers, pg, adr[23:13], adr[12:6]}) : '0;
    apb(1'b1, IDX_CTRL, {16'h0, c & 16'h7fff}, rd, serr);
    apb(1'b1, IDX_KEY, 32'h55, rd, serr);
    if (brk) apb(1'b1, IDX_ADRL, 32'h0, rd, serr);
    apb(1'b1, IDX_KEY, 32'haa, rd, serr);
    apb(1'b1, IDX_CTRL, {16'h0, c}, rd, serr);
    chk(cpuStall, on);
    chk(flashCmd, e);
    n = 0;
    // one stall cycle passes inside the bus task, the last look sees it end
    while (cpuStall === 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    chk(n, on ? OPL : 0);
    apb(1'b0, IDX_CTRL, 32'h0, rd, serr);
    if (on) chk(rd[15:0], c & 16'h7fff);
    else chk({rd[15], rd[13]}, 2'b01);
    apb(1'b1, IDX_CTRL, {16'h0, c & 16'h5fff}, rd, serr);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end

  initial begin
    seed = 96257;
    n_fail = 0;
    tests_run = 0;
    {arst_n, psel, penable, pwrite} = 4'h0;
    paddr = '0;
    pwdata = '0;
    tablePage = 8'h0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    tablePage <= 8'($random(seed));
    // reset value, write-only key and an unmapped hole
    apb(1'b0, IDX_CTRL, 32'h0, rd, serr);
    chk(rd, 32'h0);
    apb(1'b0, IDX_KEY, 32'h0, rd, serr);
    chk(rd, 32'h0);
    apb(1'b0, IDX_CTRL + 12'h1, 32'h0, rd, serr);
    chk({serr, rd}, {1'b1, 32'h0});
    // ascending fill of one aligned group
    base = 16'($random(seed)) & 16'hffc0;
    for (int i = 0; i < ROW_INSTR; i++) begin
      wd = 16'($random(seed));
      core.tbl(1'b1, 1'b0, base + 16'(2 * i), wd, rdt, n);
      chk(n, 1);
      lat[i][15:0] = wd;
      wd = 16'($random(seed));
      core.tbl(1'b1, 1'b1, base + 16'(2 * i), wd, rdt, n);
      lat[i][23:16] = wd[7:0];
    end
    for (int i = 0; i < ROW_INSTR; i++) begin
      chk(flashLatchData[24 * i +: 24], lat[i]);
    end
    adr = {tablePage, base + 16'd62};
    chk(pmAddr, adr);
    apb(1'b0, IDX_ADRL, 32'h0, rd, serr);
    chk(rd, adr[15:0]);
    apb(1'b0, IDX_ADRU, 32'h0, rd, serr);
    chk(rd, adr[23:16]);
    // low then high read of the group's first word
    adr = {tablePage, base};
    x = arr(adr);
    for (int h = 0; h < 2; h++) begin
      core.tbl(1'b0, h[0], base, 16'h0, rdt, n);
      chk(n, 2);
      chk(rdt, h ? {8'h0, x[23:16]} : x[15:0]);
    end
    // program the row captured by the table accesses
    do_op(16'hc001, 1'b0, 1'b0, 1'b1, 1'b1);
    // direct address, then the documented row erase setting
    adr = 24'($random(seed));
    apb(1'b1, IDX_ADRU, {24'h0, adr[23:16]}, rd, serr);
    apb(1'b1, IDX_ADRL, {16'h0, adr[15:0]}, rd, serr);
    do_op(16'hc041, 1'b0, 1'b1, 1'b0, 1'b1);
    // refused starts: broken key pair, then write enable clear
    do_op(16'hc041, 1'b1, 1'b1, 1'b0, 1'b0);
    do_op(16'h8041, 1'b0, 1'b1, 1'b0, 1'b0);
    finish_test();
  end
endmodule
